// ===== rtl/gcs_pkg.sv
/*
  constants for the gauge control and status register set: offsets,
  bit positions, eeprom block map, opcodes, identity layout and timing.
  assumes the bus protocol engine decodes byte addresses on its own.
*/
package gcs_pkg;

  // register offsets in the linear byte space
  localparam logic [7:0] ADDR_POWER_MODE  = 8'h01;
  localparam logic [7:0] ADDR_COPY_LOCK   = 8'h07;
  localparam logic [7:0] ADDR_FEATURE     = 8'h08;
  localparam logic [7:0] ADDR_DEFAULTS    = 8'h31;

  // eeprom block bounds
  localparam logic [7:0] EE_BLK0_LO       = 8'h20;
  localparam logic [7:0] EE_BLK1_LO       = 8'h40;
  localparam logic [7:0] EE_BLK2_LO       = 8'h60;
  localparam logic [7:0] EE_BLK2_HI       = 8'h7F;

  // power mode config bit positions
  localparam int unsigned PM_SUSP_HI      = 7;
  localparam int unsigned PM_SUSP_LO      = 6;
  localparam int unsigned PM_LOW_POWER    = 5;
  localparam int unsigned PM_OPCODE_SEL   = 4;
  localparam int unsigned PM_UV_SLEEP     = 3;
  localparam int unsigned PM_ALARM_SEL    = 2;
  localparam int unsigned PM_OFFSET_BLANK = 1;
  localparam int unsigned PM_FAST_TIMING  = 0;

  // copy and lock state bit positions
  localparam int unsigned CL_COPY_BUSY    = 7;
  localparam int unsigned CL_LOCK_ARM     = 6;
  localparam int unsigned CL_BLK2         = 2;
  localparam int unsigned CL_BLK0         = 0;

  // special feature bit positions
  localparam int unsigned SF_POWER_ON     = 7;
  localparam int unsigned SF_PROG_PIN     = 6;
  localparam int unsigned SF_ALARM_EN     = 2;
  localparam int unsigned SF_CAPTURE      = 0;

  // suspend period encodings
  typedef enum logic [1:0] {
    SUSP_OFF    = 2'b00,
    SUSP_2HZ    = 2'b01,
    SUSP_1HZ    = 2'b10,
    SUSP_HALFHZ = 2'b11
  } gcs_susp_e;

  // identity read opcodes
  localparam logic [7:0] OP_ID_READ_0     = 8'h33;
  localparam logic [7:0] OP_ID_READ_1     = 8'h39;

  // identity address field widths
  localparam int unsigned ID_FAMILY_W     = 8;
  localparam int unsigned ID_SERIAL_W     = 48;
  localparam int unsigned ID_CRC_W        = 8;

  // timing: clock and undervoltage delay
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned UV_DELAY_US     = 1000;
  localparam int unsigned UV_DELAY_CYC    = (UV_DELAY_US * 1000) / CLK_PERIOD_NS;

endpackage : gcs_pkg

// ===== rtl/gcs_regs.sv
/*
  gauge control and status register set: power mode config, eeprom copy
  and lock state, special feature flags, identity address and the
  undervoltage sleep qualifier.
  assumes a protocol engine on i_clk presenting byte writes and reads,
  an eeprom store on i_clk presenting the default byte and lock flags,
  and an asynchronous undervoltage comparator level on a pin.
*/
`timescale 1ns/100ps
`default_nettype none

module gcs_regs #(
  parameter int unsigned     UV_DELAY_CYC = gcs_pkg::UV_DELAY_CYC,
  parameter logic [7:0]      FAMILY_CODE  = 8'hA5,          // arbitrary value
  parameter logic [47:0]     SERIAL_NUM   = 48'h0000_0000_0001,
  parameter logic [7:0]      ID_CRC       = 8'h00            // arbitrary value
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_sys_rst,
  // register access from the protocol engine
  input  wire logic          i_reg_wr,
  input  wire logic          i_reg_rd,
  input  wire logic [7:0]    i_reg_addr,
  input  wire logic [7:0]    i_reg_wdata,
  output logic [7:0]         o_reg_rdata,
  output logic               o_reg_hit,
  output logic               o_ee_wr_ok,
  // eeprom store
  input  wire logic [7:0]    i_default_byte,
  input  wire logic          i_recall_blk0,
  input  wire logic [2:0]    i_lock_state,
  input  wire logic          i_copy_busy,
  input  wire logic          i_lock_cmd,
  input  wire logic [7:0]    i_lock_addr,
  output logic [2:0]         o_lock_set,
  // events from bus and converter
  input  wire logic          i_bus_reset,
  input  wire logic          i_snapshot_done,
  input  wire logic          i_alarm_cmp,
  input  wire logic          i_cell_below_uv,
  // configuration and status outputs
  output logic [1:0]         o_suspend_period,
  output logic               o_suspend_en,
  output logic               o_low_power_allow,
  output logic [7:0]         o_id_read_opcode,
  output logic               o_uv_sleep_req,
  output logic               o_alarm_to_bus,
  output logic               o_alarm_to_pin,
  output logic               o_alarm_regs_active,
  output logic               o_offset_blank_en,
  output logic               o_fast_timing_en,
  output logic               o_snapshot_hold,
  output logic               o_prog_pin_bit,
  output logic [63:0]        o_id_address
);

  localparam int unsigned UVW = $clog2(UV_DELAY_CYC + 1);

  if (UV_DELAY_CYC < 1) begin : g_chk_uv
    $error("UV_DELAY_CYC must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]     power_mode_config;
  logic           copy_in_progress;
  logic           lock_arm;
  logic [2:0]     block_protect;
  logic           power_on_flag;
  logic           prog_pin_bit;
  logic           alarm_signal_en;
  logic           capture_flag;
  logic           por_load;
  logic           uv_meta;
  logic           uv_sync;
  logic [UVW-1:0] uv_count;

  function automatic logic [1:0] blk_of(input logic [7:0] a);
    blk_of = a[6:5] - 2'd1;
  endfunction : blk_of

  function automatic logic in_ee(input logic [7:0] a);
    in_ee = (a >= gcs_pkg::EE_BLK0_LO) && (a <= gcs_pkg::EE_BLK2_HI);
  endfunction : in_ee

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire        wr_copy_lock = i_reg_wr && (i_reg_addr == gcs_pkg::ADDR_COPY_LOCK);
  wire        wr_feature   = i_reg_wr && (i_reg_addr == gcs_pkg::ADDR_FEATURE);
  wire        hit_pm       = (i_reg_addr == gcs_pkg::ADDR_POWER_MODE);
  wire        hit_cl       = (i_reg_addr == gcs_pkg::ADDR_COPY_LOCK);
  wire        hit_sf       = (i_reg_addr == gcs_pkg::ADDR_FEATURE);
  wire [1:0]  wr_blk       = blk_of(i_reg_addr);
  wire [1:0]  lk_blk       = blk_of(i_lock_addr);
  wire        lock_fire    = i_lock_cmd && lock_arm && in_ee(i_lock_addr);
  // the power-on load and the block 0 recall are the only writers of the config byte
  wire        load_cfg     = por_load || i_recall_blk0;

  wire [7:0]  copy_lock_view  = {copy_in_progress, lock_arm, 3'h0, block_protect};
  wire [7:0]  feature_view    = {power_on_flag, prog_pin_bit, 3'h0, alarm_signal_en,
                                 1'b0, capture_flag};

  wire [7:0]  next_rdata = hit_pm ? power_mode_config :
                           hit_cl ? copy_lock_view :
                           hit_sf ? feature_view : 8'h00;

  wire [1:0]  susp      = power_mode_config[gcs_pkg::PM_SUSP_HI:gcs_pkg::PM_SUSP_LO];
  wire        low_power = power_mode_config[gcs_pkg::PM_LOW_POWER];
  wire        alarm_ok  = alarm_signal_en && (susp == gcs_pkg::SUSP_OFF)
                          && i_alarm_cmp;
  wire        uv_armed  = low_power && power_mode_config[gcs_pkg::PM_UV_SLEEP];
  wire        uv_done   = (uv_count == UVW'(UV_DELAY_CYC));

  ////////////////////////////////////////////////////////////////////////////
  // config byte, loaded once after reset release and on each block 0 recall

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      por_load <= 1'b1;
    end else begin
      por_load <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      power_mode_config <= 8'h00;
    end else if (load_cfg) begin
      power_mode_config <= i_default_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // copy and lock state

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      copy_in_progress <= 1'b0;
      lock_arm         <= 1'b0;
      block_protect    <= 3'h0;
    end else begin
      copy_in_progress <= i_copy_busy;
      if (lock_fire) begin
        lock_arm <= 1'b0;
      end else if (wr_copy_lock) begin
        lock_arm <= i_reg_wdata[gcs_pkg::CL_LOCK_ARM];
      end
      // protect flags come from the nonvolatile state, and only grow
      if (por_load) begin
        block_protect <= i_lock_state;
      end else if (lock_fire) begin
        block_protect[lk_blk] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // special feature flags; hardware set beats a host clear

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      power_on_flag   <= 1'b1;
      prog_pin_bit    <= 1'b0;
      alarm_signal_en <= 1'b0;
      capture_flag    <= 1'b0;
    end else begin
      if (wr_feature && !i_reg_wdata[gcs_pkg::SF_POWER_ON]) begin
        power_on_flag <= 1'b0;
      end
      if (wr_feature) begin
        prog_pin_bit <= i_reg_wdata[gcs_pkg::SF_PROG_PIN];
      end
      if (i_bus_reset) begin
        alarm_signal_en <= 1'b0;
      end else if (wr_feature) begin
        alarm_signal_en <= i_reg_wdata[gcs_pkg::SF_ALARM_EN];
      end
      if (i_snapshot_done) begin
        capture_flag <= 1'b1;
      end else if (wr_feature && !i_reg_wdata[gcs_pkg::SF_CAPTURE]) begin
        capture_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // undervoltage qualifier; the comparator is asynchronous to i_clk

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      uv_meta  <= 1'b0;
      uv_sync  <= 1'b0;
      uv_count <= '0;
    end else begin
      uv_meta <= i_cell_below_uv;
      uv_sync <= uv_meta;
      // any recovery above threshold restarts the whole delay
      if (!uv_sync || !uv_armed) begin
        uv_count <= '0;
      end else if (!uv_done) begin
        uv_count <= uv_count + UVW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and registered outputs

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata    <= 8'h00;
      o_uv_sleep_req <= 1'b0;
      o_alarm_to_bus <= 1'b0;
      o_alarm_to_pin <= 1'b0;
    end else begin
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
      o_uv_sleep_req <= uv_armed && uv_done;
      o_alarm_to_bus <= alarm_ok && power_mode_config[gcs_pkg::PM_ALARM_SEL];
      o_alarm_to_pin <= alarm_ok && !power_mode_config[gcs_pkg::PM_ALARM_SEL];
    end
  end

  assign o_reg_hit           = hit_pm || hit_cl || hit_sf;
  assign o_ee_wr_ok          = in_ee(i_reg_addr) && !copy_in_progress
                               && !block_protect[wr_blk];
  assign o_lock_set          = block_protect;
  assign o_suspend_period    = susp;
  assign o_suspend_en        = low_power && (susp != gcs_pkg::SUSP_OFF);
  assign o_low_power_allow   = low_power;
  assign o_id_read_opcode    = power_mode_config[gcs_pkg::PM_OPCODE_SEL] ?
                               gcs_pkg::OP_ID_READ_1 : gcs_pkg::OP_ID_READ_0;
  assign o_alarm_regs_active = alarm_signal_en;
  assign o_offset_blank_en   = power_mode_config[gcs_pkg::PM_OFFSET_BLANK];
  assign o_fast_timing_en    = power_mode_config[gcs_pkg::PM_FAST_TIMING];
  assign o_snapshot_hold     = capture_flag;
  assign o_prog_pin_bit      = prog_pin_bit;
  // crc is a constant; nothing here compares it
  assign o_id_address        = {ID_CRC, SERIAL_NUM, FAMILY_CODE};

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_cfg_only_recall: assert property (!load_cfg |=> $stable(power_mode_config))
    else $error("config byte changed without recall");
  a_cfg_recall_load: assert property (load_cfg |=> power_mode_config == $past(i_default_byte))
    else $error("recall did not load default byte");
  a_copy_blocks_wr: assert property (copy_in_progress |-> !o_ee_wr_ok)
    else $error("eeprom write allowed during copy");
  a_lock_clears_arm: assert property (lock_fire |=> !lock_arm && block_protect[$past(lk_blk)])
    else $error("lock did not protect block and disarm");
  a_lock_needs_arm: assert property (!lock_arm && !por_load |=> $stable(block_protect))
    else $error("block locked while disarmed");
  a_por_flag_sticky: assert property (power_on_flag && !wr_feature |=> power_on_flag)
    else $error("power-on flag lost without write");
  a_bus_rst_alarm: assert property (i_bus_reset |=> !alarm_signal_en)
    else $error("bus reset left alarm enabled");
  a_capture_set: assert property (i_snapshot_done |=> capture_flag)
    else $error("snapshot did not set capture flag");
  a_alarm_gated: assert property ((o_alarm_to_bus || o_alarm_to_pin) |->
                                  $past(alarm_signal_en) && $past(susp) == 2'b00)
    else $error("alarm signalled while disabled");
  a_uv_delay: assert property (o_uv_sleep_req |-> $past(uv_sync, 2) && $past(uv_armed))
    else $error("undervolt sleep without qualified level");
  a_opcode_sel: assert property (o_id_read_opcode == (power_mode_config[4] ? 8'h39 : 8'h33))
    else $error("wrong identity read opcode");

  c_lock_event:   cover property (lock_fire);
  c_snapshot_clr: cover property (capture_flag ##1 wr_feature ##1 !capture_flag);
  c_uv_sleep:     cover property ($rose(o_uv_sleep_req));

endmodule : gcs_regs

`default_nettype wire

// ===== testbench/gcs_host_model.sv
/*
  host side of the single-wire bus: works out the identity crc.
  assumes the identity address is presented whole and stays still.
*/
`timescale 1ns/100ps
`default_nettype none

module gcs_host_model (
  // identity address read from the device
  input  wire logic [63:0] i_id_address,
  // crc as the host works it out
  output logic      [7:0]  o_crc,
  output logic             o_crc_match
);
  logic [7:0] acc;
  logic       fb;

  // only the host may act on a mismatch; the device keeps going
  always_comb begin
    acc = 8'h00;
    fb  = 1'b0;
    for (int i = 0; i < 56; i++) begin
      fb  = acc[0] ^ i_id_address[i];
      acc = {fb, acc[7:1]} ^ (fb ? 8'h0C : 8'h00);
    end
    o_crc       = acc;
    o_crc_match = (acc == i_id_address[63:56]);
  end
endmodule : gcs_host_model

`default_nettype wire

// ===== testbench/gcs_regs_tb_top.sv
/*
  self-checking bench for the gauge register set.
  assumes inputs change on the falling edge and a short undervolt delay.
*/
`timescale 1ns/100ps
`default_nettype none

module gcs_regs_tb_top;
  localparam int unsigned UV  = 8;
  localparam logic [7:0]  FAM = 8'h5A;  // arbitrary value
  localparam logic [47:0] SER = 48'h0000_1234_5678;
  localparam logic [7:0]  CRC = 8'h3C;  // arbitrary value
  localparam logic [7:0]  CORNER [3] = '{8'h00, 8'hFF, 8'h04};

  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_default_byte = 8'h00;
  logic i_recall_blk0 = 1'b0, i_copy_busy = 1'b0, i_lock_cmd = 1'b0;
  logic [2:0] i_lock_state = 3'b001;
  logic [7:0] i_lock_addr = 8'h00;
  logic i_bus_reset = 1'b0, i_snapshot_done = 1'b0, i_alarm_cmp = 1'b0;
  logic i_cell_below_uv = 1'b0;
  logic [7:0] o_reg_rdata, o_id_read_opcode, host_crc, q, b;
  logic [2:0] o_lock_set;
  logic [1:0] o_suspend_period;
  logic [63:0] o_id_address;
  logic o_reg_hit, o_ee_wr_ok, o_suspend_en, o_low_power_allow, o_uv_sleep_req;
  logic o_alarm_to_bus, o_alarm_to_pin, o_alarm_regs_active, o_offset_blank_en;
  logic o_fast_timing_en, o_snapshot_hold, o_prog_pin_bit, host_match, s;
  logic [31:0] seed = 32'h0001_782B;  // 96299
  int failures = 0, checked = 0, n;

  gcs_regs #(.UV_DELAY_CYC(UV), .FAMILY_CODE(FAM), .SERIAL_NUM(SER), .ID_CRC(CRC))
    i_gcs_regs (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .o_reg_hit(o_reg_hit), .o_ee_wr_ok(o_ee_wr_ok), .i_default_byte(i_default_byte),
      .i_recall_blk0(i_recall_blk0), .i_lock_state(i_lock_state),
      .i_copy_busy(i_copy_busy), .i_lock_cmd(i_lock_cmd), .i_lock_addr(i_lock_addr),
      .o_lock_set(o_lock_set), .i_bus_reset(i_bus_reset),
      .i_snapshot_done(i_snapshot_done), .i_alarm_cmp(i_alarm_cmp),
      .i_cell_below_uv(i_cell_below_uv), .o_suspend_period(o_suspend_period),
      .o_suspend_en(o_suspend_en), .o_low_power_allow(o_low_power_allow),
      .o_id_read_opcode(o_id_read_opcode), .o_uv_sleep_req(o_uv_sleep_req),
      .o_alarm_to_bus(o_alarm_to_bus), .o_alarm_to_pin(o_alarm_to_pin),
      .o_alarm_regs_active(o_alarm_regs_active), .o_offset_blank_en(o_offset_blank_en),
      .o_fast_timing_en(o_fast_timing_en), .o_snapshot_hold(o_snapshot_hold),
      .o_prog_pin_bit(o_prog_pin_bit), .o_id_address(o_id_address));
  gcs_host_model i_gcs_host_model (.i_id_address(o_id_address), .o_crc(host_crc),
    .o_crc_match(host_match));

  always #2 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  function automatic logic [7:0] exp_op(input logic [7:0] v);
    return v[4] ? 8'h39 : 8'h33;
  endfunction : exp_op

  // reflected shift form, written tap by tap so it does not mirror the model
  function automatic logic [7:0] crc_of(input logic [55:0] v);
    logic [7:0] c;
    logic       f;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      f = c[0] ^ v[i];
      c = {f, c[7:5], c[4] ^ f, c[3] ^ f, c[2:1]};
    end
    return c;
  endfunction : crc_of

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic final_report;
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_reg_wr    = 1'b1;
    i_reg_addr  = a;
    i_reg_wdata = d;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    i_reg_rd   = 1'b1;
    i_reg_addr = a;
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    d        = o_reg_rdata;
  endtask : rd

  task automatic recall(input logic [7:0] v);
    @(negedge i_clk);
    i_default_byte = v;
    i_recall_blk0  = 1'b1;
    @(negedge i_clk);
    i_recall_blk0 = 1'b0;
  endtask : recall

  task automatic lockc(input logic [7:0] a);
    @(negedge i_clk);
    i_lock_cmd  = 1'b1;
    i_lock_addr = a;
    @(negedge i_clk);
    i_lock_cmd = 1'b0;
    @(negedge i_clk);
  endtask : lockc

  task automatic ee_ok(input logic [7:0] a, input logic e);
    @(negedge i_clk);
    i_reg_addr = a;
    #1 chk("ee_wr_ok", {7'h0, e}, {7'h0, o_ee_wr_ok});
  endtask : ee_ok

  ////////////////////////////////////////////////////////////////////////////
  // generous bound: the whole sequence needs well under 2000 cycles
  initial begin
    #(4 * 20000);
    failures++;
    final_report();
  end

  initial begin
    repeat (3) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (2) @(negedge i_clk);
    chk("id_family", FAM, o_id_address[7:0]);
    chk("id_serial", 8'h01, {7'h0, o_id_address[55:8] === SER});
    chk("id_crc", CRC, o_id_address[63:56]);
    chk("host_crc", crc_of({SER, FAM}), host_crc);
    chk("host_match", {7'h0, crc_of({SER, FAM}) == CRC}, {7'h0, host_match});
    rd(8'h08, q); chk("feature_por", 8'h80, q);
    chk("hit_mapped", 8'h01, {7'h0, o_reg_hit});
    wr(8'h08, 8'hFF); rd(8'h08, q); chk("feature_ones", 8'hC4, q);
    chk("prog_pin", 8'h01, {7'h0, o_prog_pin_bit});
    wr(8'h08, 8'h00); rd(8'h08, q); chk("feature_zero", 8'h00, q);
    @(negedge i_clk); i_snapshot_done = 1'b1;
    @(negedge i_clk); i_snapshot_done = 1'b0;
    wr(8'h08, 8'hFF); rd(8'h08, q); chk("capture_set", 8'h45, q);
    chk("capture_flag_hold", 8'h01, {7'h0, o_snapshot_hold});
    wr(8'h08, 8'h00); chk("capture_flag_clr", 8'h00, {7'h0, o_snapshot_hold});
    rd(8'h05, q); chk("unmapped", 8'h00, q);
    chk("hit", 8'h00, {7'h0, o_reg_hit});
    // copy, lock arm and protect flags
    rd(8'h07, q); chk("lock_init", 8'h01, q);
    ee_ok(8'h25, 1'b0); ee_ok(8'h45, 1'b1); ee_ok(8'h85, 1'b0);
    @(negedge i_clk); i_copy_busy = 1'b1;
    rd(8'h07, q); rd(8'h07, q); chk("copy_flag", 8'h81, q);
    ee_ok(8'h45, 1'b0);
    @(negedge i_clk); i_copy_busy = 1'b0;
    lockc(8'h45); chk("lock_unarmed", 8'h01, {5'h0, o_lock_set});
    wr(8'h07, 8'hFF); rd(8'h07, q); chk("lock_arm", 8'h41, q);
    lockc(8'h45); rd(8'h07, q); chk("lock_done", 8'h03, q);
    // configuration recall, corners then random bytes
    for (int k = 0; k < 10; k++) begin
      if (k < 3) begin
        b = CORNER[k];
      end else begin
        seed = xs(seed);
        b    = seed[7:0];
      end
      recall(b);
      s = (b[7:6] == 2'b00);
      chk("cfg_bits", {2'h0, b[7:5], b[1:0], b[5] & ~s},
          {2'h0, o_suspend_period, o_low_power_allow, o_offset_blank_en,
           o_fast_timing_en, o_suspend_en});
      chk("opcode", exp_op(b), o_id_read_opcode);
      rd(8'h01, q); chk("cfg_read", b, q);
      wr(8'h01, ~b); rd(8'h01, q); chk("cfg_ro", b, q);
      wr(8'h08, 8'h04);
      i_alarm_cmp = 1'b1;
      repeat (2) @(negedge i_clk);
      chk("alarm", {5'h0, b[2] & s, ~b[2] & s, 1'b1},
          {5'h0, o_alarm_to_bus, o_alarm_to_pin, o_alarm_regs_active});
      @(negedge i_clk); i_bus_reset = 1'b1;
      @(negedge i_clk); i_bus_reset = 1'b0;
      @(negedge i_clk);
      chk("bus_reset", 8'h00,
          {5'h0, o_alarm_to_bus, o_alarm_to_pin, o_alarm_regs_active});
      i_alarm_cmp = 1'b0;
    end
    // undervoltage sleep
    recall(8'h28);
    i_cell_below_uv = 1'b1;
    n = 0;
    while (o_uv_sleep_req !== 1'b1 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    chk("uv_delay", 8'(UV + 3), 8'(n));
    i_cell_below_uv = 1'b0;
    recall(8'h20);
    repeat (4) @(negedge i_clk);
    i_cell_below_uv = 1'b1;
    repeat (40) @(negedge i_clk);
    chk("uv_blocked", 8'h00, {7'h0, o_uv_sleep_req});
    recall(8'h08);
    repeat (20) @(negedge i_clk);
    chk("uv_no_low_power", 8'h00, {7'h0, o_uv_sleep_req});
    // second power-on: defaults and nonvolatile lock state reload
    i_cell_below_uv = 1'b0;
    i_default_byte  = 8'h5C;
    i_lock_state    = 3'b110;
    i_sys_rst       = 1'b1;
    repeat (2) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (2) @(negedge i_clk);
    rd(8'h01, q); chk("por_recall", 8'h5C, q);
    rd(8'h08, q); chk("por_flag_again", 8'h80, q);
    rd(8'h07, q); chk("por_lock_state", 8'h06, q);
    ee_ok(8'h25, 1'b1); ee_ok(8'h65, 1'b0);
    final_report();
  end
endmodule : gcs_regs_tb_top

`default_nettype wire
